// ==== core/status_reporting_model.sv ====
/*
 * Status reporting logic for the remote-control port: per-interface status
 * byte, service request enable, event status and enable, last-error codes,
 * request-service flag, and one fault queue shared by all interfaces.
 * Assumes the command parser issues at most one command per cycle, all
 * inputs except the supply fault pin come from logic on i_clk.
 */
`timescale 1ns/100ps

// Function
// - Master summary set when any enabled byte bit set; 64 ignored.
// - Event summary set when any enabled event status bit is set.
// - Message available follows output queue non-empty.
// - Fault bit high while fault queue holds any entry.
// - Supply fault bit follows the supply fault condition alone.
// - Status byte weights 128, 2 and 1 always read zero.
// - Status byte is read-only, values 0 to 127.
// - Service request enable keeps weights 32, 16 and 8 only, rest read zero.
// - Serial poll returns request-service flag in master summary place.
// - Serial poll clears request-service flag, master summary unchanged.
// - Event bits sticky; cleared by read, clear, device reset; reset clears all but power-on.
// - Power-on event bit set when power is applied.
// - User request, device error, request control event bits read zero.
// - Syntax error sets command error, stores code, discards later parts.
// - Execution error sets its bit, stores code, discards later commands.
// - Query error sets its bit and stores its code.
// - Operation complete command sets its event bit immediately.
// - Last-error codes hold until overwritten or cleared.
// - Reading a last-error code with its flag clear returns then clears.
// - Fault queue is FIFO; empty read returns zero.
// - Full fault queue overwrites its oldest entry.
// - Clear and device reset leave fault queue and fault bit alone.
// - Service request enable write is ANDed with fixed keep mask.
// - Separate status registers per interface, one shared fault queue.
// - Clear status clears that interface's errors and events, and so its event summary.
module status_reporting_model
   import status_reporting_pkg::*;
#(
   parameter int N_IFACE = 2,
   parameter int FAULT_DEPTH = 16,
   parameter int CODE_W = 16,
   localparam int IW = (N_IFACE > 1) ? $clog2(N_IFACE) : 1
) (
   input wire logic i_clk, // System clock
   input wire logic i_reset, // Processor reset
   input wire logic i_cmd_valid, // Command strobe
   input wire cmd_t i_cmd, // Command code
   input wire logic [IW-1:0] i_cmd_iface, // Interface issuing command
   input wire logic [7:0] i_cmd_data, // Write data
   input wire logic i_err_valid, // Error event strobe
   input wire err_kind_t i_err_kind, // Error class
   input wire logic [IW-1:0] i_err_iface, // Interface with the error
   input wire logic [CODE_W-1:0] i_err_code, // Error code
   input wire logic [N_IFACE-1:0] i_output_pending, // Output queue non-empty
   input wire logic i_supply_fault, // Supply fault pin, asynchronous
   input wire logic i_fault_valid, // Fault record strobe
   input wire logic [CODE_W-1:0] i_fault_code, // Fault record value
   output logic o_rsp_valid, // Read answer strobe
   output logic [CODE_W-1:0] o_rsp_data, // Read answer
   output logic [N_IFACE-1:0] o_request_service, // Request-service flags
   output logic [N_IFACE-1:0] o_discard_rest // Drop rest of command
);

   localparam int PW = $clog2(FAULT_DEPTH);

   // Pointer wrap needs a power-of-two depth; answers hold a full byte
   if (N_IFACE < 1 || FAULT_DEPTH < 2 || CODE_W < 8 ||
         (FAULT_DEPTH & (FAULT_DEPTH - 1)) != 0) begin : g_bad_params
      $error("status_reporting_model: unsupported parameters");
   end

   // Supply fault pin synchroniser
   logic [SUPPLY_SYNC_STAGES-1:0] supply_sync;
   logic supply_fault;

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         supply_sync <= '0;
      end else begin
         supply_sync <= {supply_sync[SUPPLY_SYNC_STAGES-2:0], i_supply_fault};
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         supply_fault <= 1'b0;
      end else if (supply_sync[2] == supply_sync[1]) begin
         supply_fault <= supply_sync[2];
      end
   end

   // Shared fault queue
   logic [CODE_W-1:0] fault_mem [FAULT_DEPTH];
   logic [PW-1:0] fault_wr;
   logic [PW-1:0] fault_rd;
   logic [PW:0] fault_count;
   logic fault_pending;

   wire fault_empty = (fault_count == '0);
   wire fault_full = (fault_count == (PW+1)'(FAULT_DEPTH));
   // Commands for an absent interface are ignored, fault reads included
   wire iface_ok = (int'(i_cmd_iface) < N_IFACE);
   wire fault_pop = i_cmd_valid && iface_ok && (i_cmd == CMD_READ_FAULT) &&
      !fault_empty;
   wire fault_push = i_fault_valid;
   wire fault_drop = fault_push && fault_full && !fault_pop;
   wire [CODE_W-1:0] fault_head = fault_empty ? '0 : fault_mem[fault_rd];

   always_ff @(posedge i_clk) begin
      if (fault_push) begin
         fault_mem[fault_wr] <= i_fault_code;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         fault_wr <= '0;
         fault_rd <= '0;
         fault_count <= '0;
      end else begin
         if (fault_push) begin
            fault_wr <= fault_wr + 1'b1;
         end
         if (fault_pop || fault_drop) begin
            fault_rd <= fault_rd + 1'b1;
         end
         if (fault_push && !fault_pop && !fault_full) begin
            fault_count <= fault_count + 1'b1;
         end else if (fault_pop && !fault_push) begin
            fault_count <= fault_count - 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         fault_pending <= 1'b0;
      end else begin
         fault_pending <= !fault_empty;
      end
   end

   // Per-interface state
   // one copy per interface
   logic [7:0] service_request_enable [N_IFACE];
   logic [7:0] event_enable_mask [N_IFACE];
   logic [7:0] event_status [N_IFACE];
   logic [CODE_W-1:0] last_command_error_code [N_IFACE];
   logic [CODE_W-1:0] last_execution_error_code [N_IFACE];
   logic [CODE_W-1:0] last_query_error_code [N_IFACE];
   logic [N_IFACE-1:0] master_summary;
   logic [N_IFACE-1:0] event_summary;
   logic [N_IFACE-1:0] message_available;
   logic [7:0] status_byte [N_IFACE];
   logic [7:0] poll_byte [N_IFACE];

   for (genvar g = 0; g < N_IFACE; g++) begin : g_iface
      wire here = i_cmd_valid && (i_cmd_iface == IW'(g));
      wire err_here = i_err_valid && (i_err_iface == IW'(g));
      wire cmd_err = err_here && (i_err_kind == ERR_COMMAND);
      wire exec_err = err_here && (i_err_kind == ERR_EXECUTION);
      wire query_err = err_here && (i_err_kind == ERR_QUERY);
      wire clear_all = here &&
         (i_cmd == CMD_CLEAR_STATUS || i_cmd == CMD_DEVICE_RESET);
      wire es_read = here && (i_cmd == CMD_READ_EVENTS);
      wire op_done = here && (i_cmd == CMD_OP_COMPLETE);
      wire [7:0] es_set = {2'b00, cmd_err, exec_err, 1'b0, query_err,
         1'b0, op_done};
      wire [7:0] next_event_status =
         (((clear_all || es_read) ? 8'h00 : event_status[g]) | es_set)
         & ES_USED_MASK;
      wire event_cond = |(event_status[g] & event_enable_mask[g]);
      wire [7:0] summary_src = {2'b00, event_cond, i_output_pending[g],
         !fault_empty, supply_fault, 2'b00};
      wire next_master = |(service_request_enable[g] & summary_src);
      wire poll = here && (i_cmd == CMD_SERIAL_POLL);
      wire mss_rise = next_master && !master_summary[g];
      wire read_lce = here && (i_cmd == CMD_READ_CMD_ERR) &&
         !event_status[g][ES_COMMAND_ERR_BIT];
      wire read_lee = here && (i_cmd == CMD_READ_EXEC_ERR) &&
         !event_status[g][ES_EXEC_ERR_BIT];
      wire read_lqe = here && (i_cmd == CMD_READ_QUERY_ERR) &&
         !event_status[g][ES_QUERY_ERR_BIT];

      always_ff @(posedge i_clk or posedge i_reset) begin
         if (i_reset) begin
            event_status[g] <= ES_RESET_VALUE;
         end else begin
            event_status[g] <= next_event_status;
         end
      end

      always_ff @(posedge i_clk or posedge i_reset) begin
         if (i_reset) begin
            service_request_enable[g] <= SRE_RESET_VALUE;
            event_enable_mask[g] <= ESE_RESET_VALUE;
         end else begin
            if (here && i_cmd == CMD_WRITE_SRE) begin
               service_request_enable[g] <= i_cmd_data & SRE_KEEP_MASK;
            end
            if (here && i_cmd == CMD_WRITE_ESE) begin
               event_enable_mask[g] <= i_cmd_data;
            end
         end
      end

      always_ff @(posedge i_clk or posedge i_reset) begin
         if (i_reset) begin
            last_command_error_code[g] <= '0;
         end else if (cmd_err) begin
            last_command_error_code[g] <= i_err_code;
         end else if (clear_all || read_lce) begin
            last_command_error_code[g] <= '0;
         end
      end

      always_ff @(posedge i_clk or posedge i_reset) begin
         if (i_reset) begin
            last_execution_error_code[g] <= '0;
         end else if (exec_err) begin
            last_execution_error_code[g] <= i_err_code;
         end else if (clear_all || read_lee) begin
            last_execution_error_code[g] <= '0;
         end
      end

      always_ff @(posedge i_clk or posedge i_reset) begin
         if (i_reset) begin
            last_query_error_code[g] <= '0;
         end else if (query_err) begin
            last_query_error_code[g] <= i_err_code;
         end else if (clear_all || read_lqe) begin
            last_query_error_code[g] <= '0;
         end
      end

      always_ff @(posedge i_clk or posedge i_reset) begin
         if (i_reset) begin
            master_summary[g] <= 1'b0;
            event_summary[g] <= 1'b0;
            message_available[g] <= 1'b0;
         end else begin
            master_summary[g] <= next_master;
            event_summary[g] <= event_cond;
            message_available[g] <= i_output_pending[g];
         end
      end

      always_ff @(posedge i_clk or posedge i_reset) begin
         if (i_reset) begin
            o_request_service[g] <= 1'b0;
         end else if (mss_rise) begin
            o_request_service[g] <= 1'b1;
         end else if (poll || !next_master) begin
            o_request_service[g] <= 1'b0;
         end
      end

      always_ff @(posedge i_clk or posedge i_reset) begin
         if (i_reset) begin
            o_discard_rest[g] <= 1'b0;
         end else begin
            o_discard_rest[g] <= cmd_err || exec_err;
         end
      end

      assign status_byte[g] = {1'b0, master_summary[g], event_summary[g],
         message_available[g], fault_pending, supply_fault, 2'b00};
      assign poll_byte[g] = {1'b0, o_request_service[g],
         status_byte[g][5:0]};
   end

   // Read answer selection
   wire [IW-1:0] sel = i_cmd_iface;
   wire is_read = i_cmd_valid && iface_ok &&
      (i_cmd == CMD_READ_STATUS || i_cmd == CMD_READ_SRE ||
       i_cmd == CMD_READ_ESE || i_cmd == CMD_READ_EVENTS ||
       i_cmd == CMD_READ_CMD_ERR || i_cmd == CMD_READ_EXEC_ERR ||
       i_cmd == CMD_READ_QUERY_ERR || i_cmd == CMD_READ_FAULT ||
       i_cmd == CMD_SERIAL_POLL);
   logic [CODE_W-1:0] next_rsp_data;

   always_comb begin
      next_rsp_data = '0;
      if (iface_ok) begin
         unique case (i_cmd)
            CMD_READ_STATUS: next_rsp_data = CODE_W'(status_byte[sel]);
            CMD_READ_SRE:
               next_rsp_data = CODE_W'(service_request_enable[sel]);
            CMD_READ_ESE: next_rsp_data = CODE_W'(event_enable_mask[sel]);
            CMD_READ_EVENTS: next_rsp_data = CODE_W'(event_status[sel]);
            CMD_READ_CMD_ERR: next_rsp_data = last_command_error_code[sel];
            CMD_READ_EXEC_ERR:
               next_rsp_data = last_execution_error_code[sel];
            CMD_READ_QUERY_ERR: next_rsp_data = last_query_error_code[sel];
            CMD_READ_FAULT: next_rsp_data = fault_head;
            CMD_SERIAL_POLL: next_rsp_data = CODE_W'(poll_byte[sel]);
            default: next_rsp_data = '0;
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_rsp_valid <= 1'b0;
         o_rsp_data <= '0;
      end else begin
         o_rsp_valid <= is_read;
         if (is_read) begin
            o_rsp_data <= next_rsp_data;
         end
      end
   end

endmodule : status_reporting_model

// ==== core/status_reporting_pkg.sv ====
/*
 * Constants for the status reporting block: status byte and event status
 * bit positions, the enable keep mask, reset values and command codes.
 * Assumes a single 25 MHz system clock shared by every user of the block.
 */
package status_reporting_pkg;

   // Status byte positions
   localparam int SB_SUMMARY_BIT = 6;
   localparam int SB_EVENT_BIT = 5;
   localparam int SB_MESSAGE_BIT = 4;
   localparam int SB_FAULT_BIT = 3;
   localparam int SB_SUPPLY_BIT = 2;

   // Service request enable keeps only these positions
   localparam logic [7:0] SRE_KEEP_MASK = 8'h38;

   // Event status positions
   localparam int ES_POWER_ON_BIT = 7;
   localparam int ES_COMMAND_ERR_BIT = 5;
   localparam int ES_EXEC_ERR_BIT = 4;
   localparam int ES_QUERY_ERR_BIT = 2;
   localparam int ES_OP_COMPLETE_BIT = 0;
   localparam logic [7:0] ES_USED_MASK = 8'hB5;
   localparam logic [7:0] ES_RESET_VALUE = 8'h80;

   localparam logic [7:0] SRE_RESET_VALUE = 8'h00;
   localparam logic [7:0] ESE_RESET_VALUE = 8'h00;

   // Supply fault pin synchroniser depth
   localparam int SUPPLY_SYNC_STAGES = 3;

   typedef enum logic [3:0] {
      CMD_READ_STATUS = 4'h0,
      CMD_WRITE_SRE = 4'h1,
      CMD_READ_SRE = 4'h2,
      CMD_WRITE_ESE = 4'h3,
      CMD_READ_ESE = 4'h4,
      CMD_READ_EVENTS = 4'h5,
      CMD_CLEAR_STATUS = 4'h6,
      CMD_DEVICE_RESET = 4'h7,
      CMD_OP_COMPLETE = 4'h8,
      CMD_READ_CMD_ERR = 4'h9,
      CMD_READ_EXEC_ERR = 4'hA,
      CMD_READ_QUERY_ERR = 4'hB,
      CMD_READ_FAULT = 4'hC,
      CMD_SERIAL_POLL = 4'hD
   } cmd_t;

   typedef enum logic [1:0] {
      ERR_COMMAND = 2'h0,
      ERR_EXECUTION = 2'h1,
      ERR_QUERY = 2'h2
   } err_kind_t;

endpackage : status_reporting_pkg

// ==== dv/host_model.sv ====
/* Host controller model: issues one command at a time and collects
   the answer. Assumes commands are driven on falling clock edges. */
`timescale 1ns/100ps
module host_model
   import status_reporting_pkg::*;
#(
   parameter int IW = 1,
   parameter int CODE_W = 16
) (
   input wire logic i_clk, // System clock
   input wire logic i_rsp_valid, // Answer strobe
   input wire logic [CODE_W-1:0] i_rsp_data, // Answer value
   output logic o_cmd_valid, // Command strobe
   output cmd_t o_cmd, // Command code
   output logic [IW-1:0] o_cmd_iface, // Target interface
   output logic [7:0] o_cmd_data // Write data
);
   logic hung;
   initial begin
      hung = 1'b0;
      o_cmd_valid = 1'b0;
      o_cmd = CMD_READ_STATUS;
      o_cmd_iface = '0;
      o_cmd_data = 8'h00;
   end
   task automatic xfer(input cmd_t c, input logic [IW-1:0] f,
         input logic [7:0] d, output logic [CODE_W-1:0] r);
      int n;
      r = 'x;
      @(negedge i_clk);
      o_cmd_valid = 1'b1;
      o_cmd = c;
      o_cmd_iface = f;
      o_cmd_data = d;
      @(negedge i_clk);
      o_cmd_valid = 1'b0;
      // Released lines must not keep showing the last request
      o_cmd_data = ~d;
      o_cmd = cmd_t'(~c);
      o_cmd_iface = ~f;
      if (!(c inside {CMD_WRITE_SRE, CMD_WRITE_ESE, CMD_CLEAR_STATUS,
            CMD_DEVICE_RESET, CMD_OP_COMPLETE})) begin
         n = 0;
         while (i_rsp_valid !== 1'b1 && n < 4) begin
            @(negedge i_clk);
            n++;
         end
         if (i_rsp_valid === 1'b1) r = i_rsp_data;
         else hung = 1'b1;
      end
   endtask : xfer
endmodule : host_model

// ==== dv/status_reporting_checker.sv ====
/* Assertion checker for status_reporting_model, bound to each instance.
   Assumes one clock and watches interface 0 of the command port. */
`timescale 1ns/100ps
module status_reporting_checker
   import status_reporting_pkg::*;
#(
   parameter int N_IFACE = 2,
   parameter int FAULT_DEPTH = 16,
   parameter int CODE_W = 16,
   localparam int IW = (N_IFACE > 1) ? $clog2(N_IFACE) : 1
) (
   input wire logic i_clk, // System clock
   input wire logic i_reset, // Processor reset
   input wire logic i_cmd_valid, // Command strobe
   input wire cmd_t i_cmd, // Command code
   input wire logic [IW-1:0] i_cmd_iface, // Command interface
   input wire logic [7:0] i_cmd_data, // Write data
   input wire logic i_err_valid, // Error strobe
   input wire err_kind_t i_err_kind, // Error class
   input wire logic [IW-1:0] i_err_iface, // Error interface
   input wire logic [CODE_W-1:0] i_err_code, // Error code
   input wire logic [N_IFACE-1:0] i_output_pending, // Output queues
   input wire logic i_supply_fault, // Supply fault pin
   input wire logic i_fault_valid, // Fault strobe
   input wire logic [CODE_W-1:0] i_fault_code, // Fault value
   input wire logic o_rsp_valid, // Answer strobe
   input wire logic [CODE_W-1:0] o_rsp_data, // Answer
   input wire logic [N_IFACE-1:0] o_request_service, // Request flags
   input wire logic [N_IFACE-1:0] o_discard_rest // Discard pulses
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // Commands and errors for interface 0
   wire logic t0 = i_cmd_valid && i_cmd_iface == '0;
   wire logic rd_sb = t0 && i_cmd == CMD_READ_STATUS;
   wire logic rd_es = t0 && i_cmd == CMD_READ_EVENTS;
   wire logic err0 = i_err_valid && i_err_iface == '0;
   property p_sb_format;
      rd_sb |=> o_rsp_valid && o_rsp_data[CODE_W-1:7] == '0
         && o_rsp_data[1:0] == 2'h0;
   endproperty
   a_sb_format: assert property (p_sb_format)
      else $error("status byte format");
   property p_sre_mask;
      t0 && i_cmd == CMD_READ_SRE |=> o_rsp_valid
         && (o_rsp_data & ~CODE_W'(SRE_KEEP_MASK)) == '0;
   endproperty
   a_sre_mask: assert property (p_sre_mask)
      else $error("enable mask bits");
   property p_message;
      rd_sb && !$past(i_reset) && $stable(i_output_pending[0])
         |=> o_rsp_data[SB_MESSAGE_BIT] == $past(i_output_pending[0]);
   endproperty
   a_message: assert property (p_message)
      else $error("message bit");
   property p_poll;
      t0 && i_cmd == CMD_SERIAL_POLL
         |=> o_rsp_data[SB_SUMMARY_BIT] == $past(o_request_service[0]);
   endproperty
   a_poll: assert property (p_poll)
      else $error("poll bit");
   property p_poll_clear;
      t0 && i_cmd == CMD_SERIAL_POLL && o_request_service[0]
         |=> !o_request_service[0];
   endproperty
   a_poll_clear: assert property (p_poll_clear)
      else $error("request flag kept");
   property p_discard;
      err0 && i_err_kind != ERR_QUERY |=> o_discard_rest[0];
   endproperty
   a_discard: assert property (p_discard)
      else $error("no discard");
   property p_opc;
      t0 && i_cmd == CMD_OP_COMPLETE ##1 !i_cmd_valid ##1 rd_es
         |=> o_rsp_data[ES_OP_COMPLETE_BIT];
   endproperty
   a_opc: assert property (p_opc)
      else $error("completion bit");
   property p_sticky_clear;
      rd_es && !err0 ##1 !i_cmd_valid && !err0 ##1 rd_es |=> o_rsp_data == '0;
   endproperty
   a_sticky_clear: assert property (p_sticky_clear)
      else $error("event read clear");
   property p_sb_range;
      rd_sb |=> o_rsp_valid && o_rsp_data < CODE_W'(8'h80);
   endproperty
   a_sb_range: assert property (p_sb_range)
      else $error("status byte range");
   property p_event_unused;
      rd_es |=> o_rsp_data[6] == 1'b0 && o_rsp_data[3] == 1'b0
         && o_rsp_data[1] == 1'b0;
   endproperty
   a_event_unused: assert property (p_event_unused)
      else $error("unused event bit");
endmodule : status_reporting_checker

bind status_reporting_model status_reporting_checker #(
   .N_IFACE(N_IFACE), .FAULT_DEPTH(FAULT_DEPTH), .CODE_W(CODE_W)
) status_reporting_checker_inst (
   .i_clk(i_clk), .i_reset(i_reset), .i_cmd_valid(i_cmd_valid),
   .i_cmd(i_cmd), .i_cmd_iface(i_cmd_iface), .i_cmd_data(i_cmd_data),
   .i_err_valid(i_err_valid), .i_err_kind(i_err_kind),
   .i_err_iface(i_err_iface), .i_err_code(i_err_code),
   .i_output_pending(i_output_pending), .i_supply_fault(i_supply_fault),
   .i_fault_valid(i_fault_valid), .i_fault_code(i_fault_code),
   .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
   .o_request_service(o_request_service), .o_discard_rest(o_discard_rest)
);

// ==== dv/testbench.sv ====
/* Self-checking bench for status_reporting_model with a host model.
   Assumes 25 MHz clock; bench inputs change on falling edges. */
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
   $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module testbench
   import status_reporting_pkg::*;
;
   localparam int FD = 4;
   logic i_clk, i_reset, i_cmd_valid, i_err_valid, i_supply_fault;
   logic i_fault_valid, i_cmd_iface, i_err_iface, o_rsp_valid;
   cmd_t i_cmd;
   err_kind_t i_err_kind;
   logic [7:0] i_cmd_data;
   logic [15:0] i_err_code, i_fault_code, o_rsp_data;
   logic [1:0] i_output_pending, o_request_service, o_discard_rest;
   int total_checks = 0;
   int failures = 0;
   status_reporting_model #(.N_IFACE(2), .FAULT_DEPTH(FD), .CODE_W(16))
   status_reporting_model_inst (.i_clk(i_clk), .i_reset(i_reset),
      .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_cmd_iface(i_cmd_iface),
      .i_cmd_data(i_cmd_data), .i_err_valid(i_err_valid),
      .i_err_kind(i_err_kind), .i_err_iface(i_err_iface),
      .i_err_code(i_err_code), .i_output_pending(i_output_pending),
      .i_supply_fault(i_supply_fault), .i_fault_valid(i_fault_valid),
      .i_fault_code(i_fault_code), .o_rsp_valid(o_rsp_valid),
      .o_rsp_data(o_rsp_data), .o_request_service(o_request_service),
      .o_discard_rest(o_discard_rest));
   host_model #(.IW(1), .CODE_W(16)) host_model_inst (.i_clk(i_clk),
      .i_rsp_valid(o_rsp_valid), .i_rsp_data(o_rsp_data),
      .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd),
      .o_cmd_iface(i_cmd_iface), .o_cmd_data(i_cmd_data));
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   task automatic go(input cmd_t c, input logic f, input logic [7:0] d);
      logic [15:0] r;
      host_model_inst.xfer(c, f, d, r);
   endtask : go
   task automatic chk_rd(input cmd_t c, input logic f, input logic [15:0] e);
      logic [15:0] r;
      host_model_inst.xfer(c, f, 8'h00, r);
      if (host_model_inst.hung === 1'b1) begin
         failures++;
         stop_test();
      end
      `CHK(r, e)
   endtask : chk_rd
   task automatic err(input err_kind_t k, input logic f, input logic [15:0] c);
      @(negedge i_clk);
      i_err_valid = 1'b1;
      i_err_kind = k;
      i_err_iface = f;
      i_err_code = c;
      @(negedge i_clk);
      i_err_valid = 1'b0;
      i_err_code = ~c;
      i_err_iface = ~f;
   endtask : err
   task automatic t_reset();
      chk_rd(CMD_READ_EVENTS, 1'b0, 16'h0080);
      chk_rd(CMD_READ_EVENTS, 1'b0, 16'h0000);
      chk_rd(CMD_READ_EVENTS, 1'b1, 16'h0080);
      chk_rd(CMD_READ_SRE, 1'b0, 16'h0000);
      chk_rd(CMD_READ_STATUS, 1'b0, 16'h0000);
      $display("reset test done");
   endtask : t_reset
   task automatic t_summary();
      go(CMD_WRITE_ESE, 1'b0, 8'hFF);
      go(CMD_WRITE_SRE, 1'b0, 8'hFF);
      chk_rd(CMD_READ_SRE, 1'b0, 16'h0038);
      chk_rd(CMD_READ_ESE, 1'b0, 16'h00FF);
      chk_rd(CMD_READ_SRE, 1'b1, 16'h0000);
      go(CMD_WRITE_SRE, 1'b0, 8'h08);
      go(CMD_OP_COMPLETE, 1'b0, 8'h00);
      chk_rd(CMD_READ_EVENTS, 1'b0, 16'h0001);
      go(CMD_OP_COMPLETE, 1'b0, 8'h00);
      repeat (3) @(negedge i_clk);
      chk_rd(CMD_READ_STATUS, 1'b0, 16'h0020);
      `CHK(o_request_service, 2'b00)
      go(CMD_WRITE_SRE, 1'b0, 8'h20);
      repeat (1) @(negedge i_clk);
      `CHK(o_request_service, 2'b01)
      chk_rd(CMD_SERIAL_POLL, 1'b0, 16'h0060);
      `CHK(o_request_service, 2'b00)
      chk_rd(CMD_READ_STATUS, 1'b0, 16'h0060);
      chk_rd(CMD_READ_STATUS, 1'b1, 16'h0000);
      chk_rd(CMD_READ_EVENTS, 1'b0, 16'h0001);
      repeat (3) @(negedge i_clk);
      chk_rd(CMD_READ_STATUS, 1'b0, 16'h0000);
      $display("summary test done");
   endtask : t_summary
   task automatic t_errors();
      err(ERR_EXECUTION, 1'b0, 16'h0001);
      `CHK(o_discard_rest, 2'b01)
      chk_rd(CMD_READ_EXEC_ERR, 1'b0, 16'h0001);
      chk_rd(CMD_READ_EXEC_ERR, 1'b0, 16'h0001);
      chk_rd(CMD_READ_EVENTS, 1'b0, 16'h0010);
      chk_rd(CMD_READ_EXEC_ERR, 1'b0, 16'h0001);
      chk_rd(CMD_READ_EXEC_ERR, 1'b0, 16'h0000);
      err(ERR_COMMAND, 1'b1, 16'h00AB);
      `CHK(o_discard_rest, 2'b10)
      err(ERR_QUERY, 1'b1, 16'h0CDE);
      `CHK(o_discard_rest, 2'b00)
      chk_rd(CMD_READ_CMD_ERR, 1'b1, 16'h00AB);
      chk_rd(CMD_READ_QUERY_ERR, 1'b1, 16'h0CDE);
      go(CMD_CLEAR_STATUS, 1'b1, 8'h00);
      chk_rd(CMD_READ_QUERY_ERR, 1'b1, 16'h0000);
      chk_rd(CMD_READ_EVENTS, 1'b1, 16'h0000);
      err(ERR_EXECUTION, 1'b0, 16'h0005);
      go(CMD_DEVICE_RESET, 1'b0, 8'h00);
      chk_rd(CMD_READ_EXEC_ERR, 1'b0, 16'h0000);
      $display("error test done");
   endtask : t_errors
   task automatic t_faults();
      go(CMD_WRITE_SRE, 1'b0, 8'h00);
      for (int k = 1; k <= FD + 1; k++) begin
         @(negedge i_clk);
         i_fault_valid = 1'b1;
         i_fault_code = 16'(k);
         @(negedge i_clk);
         i_fault_valid = 1'b0;
      end
      i_output_pending = 2'b01;
      i_supply_fault = 1'b1;
      repeat (6) @(negedge i_clk);
      chk_rd(CMD_READ_STATUS, 1'b0, 16'h001C);
      go(CMD_CLEAR_STATUS, 1'b0, 8'h00);
      go(CMD_DEVICE_RESET, 1'b0, 8'h00);
      repeat (2) @(negedge i_clk);
      chk_rd(CMD_READ_STATUS, 1'b0, 16'h001C);
      chk_rd(CMD_READ_STATUS, 1'b1, 16'h000C);
      for (int k = 2; k <= FD + 1; k++) begin
         chk_rd(CMD_READ_FAULT, 1'b1, 16'(k));
      end
      chk_rd(CMD_READ_FAULT, 1'b0, 16'h0000);
      chk_rd(CMD_READ_STATUS, 1'b0, 16'h0014);
      i_output_pending = 2'b00;
      i_supply_fault = 1'b0;
      repeat (6) @(negedge i_clk);
      chk_rd(CMD_READ_STATUS, 1'b0, 16'h0000);
      $display("fault test done");
   endtask : t_faults
   task automatic t_rerun();
      go(CMD_OP_COMPLETE, 1'b0, 8'h00);
      err(ERR_QUERY, 1'b0, 16'h0042);
      @(negedge i_clk);
      i_fault_valid = 1'b1;
      @(negedge i_clk);
      i_fault_valid = 1'b0;
      i_reset = 1'b1;
      repeat (2) @(negedge i_clk);
      i_reset = 1'b0;
      chk_rd(CMD_READ_QUERY_ERR, 1'b0, 16'h0000);
      chk_rd(CMD_READ_EVENTS, 1'b0, 16'h0080);
      chk_rd(CMD_READ_FAULT, 1'b0, 16'h0000);
      $display("reset rerun test done");
   endtask : t_rerun
   initial begin
      i_reset = 1'b1;
      i_err_valid = 1'b0;
      i_err_kind = ERR_COMMAND;
      i_err_iface = 1'b0;
      i_err_code = 16'h0000;
      i_output_pending = 2'b00;
      i_supply_fault = 1'b0;
      i_fault_valid = 1'b0;
      i_fault_code = 16'h0000;
      repeat (20) @(negedge i_clk);
      i_reset = 1'b0;
      t_reset();
      t_summary();
      t_errors();
      t_faults();
      t_rerun();
      stop_test();
   end
endmodule : testbench
